/* bench/gss_engine_model.sv */
// behavioural motion engine standing behind the stop sequencer
`timescale 1ns/10ps
module gss_engine_model import gss_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_halt,
    input wire logic i_abort,
    input wire logic i_launch,
    input wire logic [7:0] i_delay,
    output logic [GSS_AXES-1:0] o_at_rest,
    output logic o_running
);
    logic moving; // axes travelling
    logic stopping; // deceleration under way, cleared by a fresh launch or once moving ends
    logic [7:0] cnt; // clocks spent decelerating
    // motion progress, one step per clock
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            moving <= 1'b0;
            stopping <= 1'b0;
            o_running <= 1'b0;
            cnt <= 8'h00;
        end else begin
            if (i_launch) o_running <= 1'b1;
            else if (i_abort) o_running <= 1'b0;
            if (i_launch) moving <= 1'b1;
            else if (stopping && cnt > i_delay + 8'h03) moving <= 1'b0;
            // a fresh launch cancels any leftover deceleration
            if (i_launch || !moving) stopping <= 1'b0;
            else if (i_halt) stopping <= 1'b1;
            cnt <= stopping ? cnt + 8'h01 : 8'h00;
        end
    end
    // axes come to rest one after another
    always_comb begin
        for (int k = 0; k < GSS_AXES; k++) o_at_rest[k] = !moving || (stopping && cnt >= i_delay + 8'(k));
    end
endmodule : gss_engine_model

/* bench/tb.sv */
// self-checking bench of the group stop sequencer
`timescale 1ns/10ps
module tb;
    import gss_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic launch = 1'b0;
    logic [7:0] dly = 8'h06;
    logic taken = 1'b0;
    logic xfault = 1'b0;
    logic ghalt = 1'b0;
    logic [GSS_AXES-1:0] rest;
    logic running;
    logic abort;
    logic irq;
    gss_motion_cmd_t cmd;
    gss_group_state_t gst;
    gss_handshake_t hso;
    logic [12:0] hs; // complete,busy,active,intr,fault,code
    logic [31:0] q;
    int n;
    int mismatches = 0;
    int check_count = 0;
    assign hs = hso;
    // 125 MHz system clock
    always #4 i_clk_sys = ~i_clk_sys;
    gss_group_axis_stop_sequencer uut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_axis_at_rest(rest), .i_other_cmd_running(running), .i_group_fault_halt(ghalt),
        .i_exec_fault(xfault), .i_taken_over(taken), .o_motion_cmd(cmd), .o_abort_other(abort),
        .o_group_state(gst), .o_handshake(hso), .o_irq(irq));
    gss_engine_model eng (.i_clk(i_clk_sys), .i_rst_n(i_reset_n), .i_halt(cmd.halt), .i_abort(abort),
        .i_launch(launch), .i_delay(dly), .o_at_rest(rest), .o_running(running));
    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, exp);
        end
    endtask : chk
    // one classic wishbone cycle, held until ack is sampled
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // ack and read data are taken at the rising edge that samples ack high
        do begin
            @(posedge i_clk_sys);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk({31'h0, ack}, 32'h0000_0001, "bus ack");
        @(negedge i_clk_sys);
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, e, "register read");
    endtask : rd
    // bounded wait for one handshake bit
    task wait_hs(input int b, input logic v);
        int k;
        k = 0;
        while (hs[b] !== v && k < 300) begin
            @(negedge i_clk_sys);
            k++;
        end
        chk({31'h0, hs[b]}, {31'h0, v}, "handshake wait");
    endtask : wait_hs
    // start a stop against a running command
    task start(input logic [7:0] d);
        @(posedge i_clk_sys);
        dly <= d;
        launch <= 1'b1;
        @(posedge i_clk_sys);
        launch <= 1'b0;
        wr(GSS_OFS_CTRL, 32'h0000_0001);
        wait_hs(11, 1'b1);
    endtask : start
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // watchdog
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        @(negedge i_clk_sys);
        chk({19'h0, hs}, 32'h0000_0000, "reset outputs");
        rd(GSS_OFS_STATUS, 32'h0000_0000);
        rd(GSS_OFS_DECEL, 32'h0000_0000);
        rd(GSS_OFS_JERK, 32'h0000_0000);
        rd(GSS_OFS_SCAN, 32'h0000_04E1);
        rd(GSS_OFS_IRQ_EN, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        wr(GSS_OFS_SCAN, 32'h0000_0002);
        $display("test reset done");
        for (int c = 1; c <= 2; c++) begin
            wr(GSS_OFS_DECEL, c == 1 ? 32'h0000_0000 : 32'h0000_0007);
            wr(GSS_OFS_JERK, c == 1 ? 32'h0000_0005 : 32'h8000_0000);
            wr(GSS_OFS_CTRL, 32'h0000_0001);
            wait_hs(8, 1'b1);
            chk({19'h0, hs}, 32'h0000_0100 + 32'(c), "bad parameter");
            wr(GSS_OFS_CTRL, 32'h0000_0000);
            wait_hs(8, 1'b0);
            chk({24'h0, hs[7:0]}, 32'h0000_0000, "code cleared");
        end
        wr(GSS_OFS_IRQ_CLR, 32'h0000_000F);
        $display("test faults on entry done");
        wr(GSS_OFS_DECEL, 32'h0000_0100);
        wr(GSS_OFS_JERK, 32'h0000_0020);
        wr(GSS_OFS_HANDLE, 32'h0000_005A);
        wr(GSS_OFS_IRQ_EN, 32'h0000_000F);
        start(8'h06);
        chk({cmd.halt, cmd.handle}, 32'h0000_015A, "group held");
        chk(cmd.decel_rate ^ cmd.jerk_limit, 32'h0000_0120, "captured shape");
        rd(GSS_OFS_STATUS, 32'h0002_0006);
        chk({31'h0, running}, 32'h0000_0000, "other aborted");
        chk({31'h0, irq}, 32'h0000_0001, "start irq");
        wr(GSS_OFS_HANDLE, 32'h0000_00A5);
        chk({24'h0, cmd.handle}, 32'h0000_005A, "handle kept");
        wait_hs(12, 1'b1);
        repeat (9) @(negedge i_clk_sys);
        rd(GSS_OFS_STATUS, 32'h0002_0005);
        rd(GSS_OFS_IRQ_STAT, 32'h0000_0003);
        wr(GSS_OFS_IRQ_CLR, 32'h0000_000F);
        chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
        wr(GSS_OFS_CTRL, 32'h0000_0000);
        wait_hs(12, 1'b0);
        wait_hs(10, 1'b0);
        chk({30'h0, gst}, 32'h0000_0000, "back to idle");
        $display("test stop done");
        wr(GSS_OFS_IRQ_EN, 32'h0000_0000);
        start(8'h0C);
        wr(GSS_OFS_CTRL, 32'h0000_0000);
        wait_hs(12, 1'b1);
        n = 0;
        while (hs[12] === 1'b1 && n < 20) begin
            n++;
            @(negedge i_clk_sys);
        end
        chk(n, 3, "complete one scan");
        chk({31'h0, hs[10]}, 32'h0000_0000, "active released");
        chk({30'h0, gst}, 32'h0000_0000, "idle after late stop");
        chk({31'h0, irq}, 32'h0000_0000, "masked irq");
        rd(GSS_OFS_IRQ_STAT, 32'h0000_0003);
        wr(GSS_OFS_IRQ_CLR, 32'h0000_000F);
        $display("test late completion done");
        wr(GSS_OFS_IRQ_EN, 32'h0000_0004);
        start(8'h28);
        chk({31'h0, irq}, 32'h0000_0000, "start masked");
        @(posedge i_clk_sys);
        taken <= 1'b1;
        wait_hs(9, 1'b1);
        chk({29'h0, hs[11:9]}, 32'h0000_0001, "interrupted");
        chk({31'h0, irq}, 32'h0000_0001, "interrupt irq");
        @(posedge i_clk_sys);
        taken <= 1'b0;
        wr(GSS_OFS_IRQ_CLR, 32'h0000_0004);
        wr(GSS_OFS_CTRL, 32'h0000_0000);
        wait_hs(9, 1'b0);
        $display("test takeover done");
        wr(GSS_OFS_IRQ_EN, 32'h0000_0008);
        for (int c = 3; c <= 4; c++) begin
            start(8'h28);
            @(posedge i_clk_sys);
            ghalt <= (c == 3);
            xfault <= (c == 4);
            wait_hs(8, 1'b1);
            chk({19'h0, hs}, 32'h0000_0100 + 32'(c), "run fault");
            chk({31'h0, irq}, 32'h0000_0001, "fault irq");
            @(posedge i_clk_sys);
            ghalt <= 1'b0;
            xfault <= 1'b0;
            wr(GSS_OFS_IRQ_CLR, 32'h0000_000F);
            wr(GSS_OFS_CTRL, 32'h0000_0000);
            wait_hs(8, 1'b0);
            chk({24'h0, hs[7:0]}, 32'h0000_0000, "code none");
        end
        $display("test run faults done");
        report_and_stop();
    end
endmodule : tb

/* hw/gss_group_axis_stop_sequencer.sv */
// group axis stop sequencer with wishbone registers and interrupt
`timescale 1ns/10ps
module gss_group_axis_stop_sequencer import gss_pkg::*; #(
    parameter int AXES = GSS_AXES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // classic wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [GSS_ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [GSS_DATA_W-1:0] i_wb_dat,
    output logic [GSS_DATA_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    // motion engine side, same clock
    input wire logic [AXES-1:0] i_axis_at_rest,
    input wire logic i_other_cmd_running,
    input wire logic i_group_fault_halt,
    input wire logic i_exec_fault,
    input wire logic i_taken_over,
    output gss_motion_cmd_t o_motion_cmd,
    output logic o_abort_other,
    output gss_group_state_t o_group_state,
    output gss_handshake_t o_handshake,
    output logic o_irq
);
    // register storage
    logic start_request;
    logic [31:0] decel_reg;
    logic [31:0] jerk_reg;
    logic [GSS_HANDLE_W-1:0] handle_reg;
    logic [15:0] scan_reg;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    // scan divider
    logic [15:0] scan_cnt;
    logic scan_tick;
    // sequencer state
    logic req_prev;
    logic op_complete;
    logic op_busy;
    logic axes_controlled;
    logic op_interrupted;
    logic op_fault;
    gss_fault_code_t fault_code;
    gss_group_state_t group_state;
    logic [31:0] decel_cap;
    logic [31:0] jerk_cap;
    logic [GSS_HANDLE_W-1:0] handle_cap;
    logic abort_pulse;

    // bus decode
    wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire bus_wr = bus_req & i_wb_we & i_wb_sel[0];
    wire wr_ctrl = bus_wr & (i_wb_adr == GSS_OFS_CTRL);
    wire wr_decel = bus_wr & (i_wb_adr == GSS_OFS_DECEL);
    wire wr_jerk = bus_wr & (i_wb_adr == GSS_OFS_JERK);
    wire wr_handle = bus_wr & (i_wb_adr == GSS_OFS_HANDLE);
    wire wr_clr = bus_wr & (i_wb_adr == GSS_OFS_IRQ_CLR);
    wire wr_en = bus_wr & (i_wb_adr == GSS_OFS_IRQ_EN);
    wire wr_scan = bus_wr & (i_wb_adr == GSS_OFS_SCAN);

    // scan edges and conditions
    wire req_rise = scan_tick & start_request & ~req_prev;
    wire req_fall = scan_tick & ~start_request & req_prev;
    wire all_rest = &i_axis_at_rest;
    wire bad_input = (decel_reg == 32'h0000_0000) | (jerk_reg == 32'h0000_0000) | decel_reg[31] | jerk_reg[31];
    wire run_fault = op_busy & (i_exec_fault | i_group_fault_halt);
    wire done_now = op_busy & axes_controlled & all_rest & ~run_fault;
    wire intr_now = op_busy & i_taken_over & ~run_fault & ~done_now;

    // read mux
    wire [31:0] status_word = {8'h00, 6'h00, group_state, fault_code, 3'b000, op_fault, op_interrupted,
        axes_controlled, op_busy, op_complete};
    logic [31:0] rd_mux;
    always_comb begin
        // unmapped addresses read zero
        unique case (i_wb_adr)
            GSS_OFS_CTRL: rd_mux = {31'h0000_0000, start_request};
            GSS_OFS_DECEL: rd_mux = decel_reg;
            GSS_OFS_JERK: rd_mux = jerk_reg;
            GSS_OFS_HANDLE: rd_mux = {24'h00_0000, handle_reg};
            GSS_OFS_STATUS: rd_mux = status_word;
            GSS_OFS_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat};
            GSS_OFS_IRQ_EN: rd_mux = {28'h000_0000, irq_en};
            GSS_OFS_SCAN: rd_mux = {16'h0000, scan_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // bus ack and read data, one wait state
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= bus_req;
            o_wb_dat <= rd_mux;
        end
    end

    // software registers
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            start_request <= 1'b0;
            decel_reg <= GSS_DECEL_RST;
            jerk_reg <= GSS_JERK_RST;
            handle_reg <= '0;
            scan_reg <= GSS_SCAN_RST;
            irq_en <= GSS_IRQ_EN_RST;
        end else begin
            if (wr_ctrl) begin
                start_request <= i_wb_dat[GSS_CTRL_START_BIT];
            end
            if (wr_decel) begin
                decel_reg <= i_wb_dat;
            end
            if (wr_jerk) begin
                jerk_reg <= i_wb_dat;
            end
            if (wr_handle) begin
                handle_reg <= i_wb_dat[GSS_HANDLE_W-1:0];
            end
            if (wr_scan) begin
                scan_reg <= i_wb_dat[15:0];
            end
            if (wr_en) begin
                irq_en <= i_wb_dat[3:0];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scan_cnt <= 16'h0000;
            scan_tick <= 1'b0;
        end else if (scan_cnt >= scan_reg) begin
            scan_cnt <= 16'h0000;
            scan_tick <= 1'b1;
        end else begin
            scan_cnt <= scan_cnt + 16'h0001;
            scan_tick <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req_prev <= 1'b0;
        end else if (scan_tick) begin
            req_prev <= start_request;
        end
    end

    // main sequencer, one step per scan
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            op_complete <= 1'b0;
            op_busy <= 1'b0;
            axes_controlled <= 1'b0;
            op_interrupted <= 1'b0;
            op_fault <= 1'b0;
            fault_code <= GSS_FAULT_NONE;
            group_state <= GSS_G_IDLE;
            decel_cap <= 32'h0000_0000;
            jerk_cap <= 32'h0000_0000;
            handle_cap <= '0;
            abort_pulse <= 1'b0;
        end else if (scan_tick) begin
            abort_pulse <= 1'b0;
            // one-scan flags when request is low
            if (op_complete && !start_request) begin
                op_complete <= 1'b0;
            end
            if (op_interrupted && !start_request) begin
                op_interrupted <= 1'b0;
            end
            // active held one scan when low
            if (axes_controlled && !start_request && !op_busy) begin
                axes_controlled <= 1'b0;
            end
            if (req_rise && !op_busy) begin
                handle_cap <= handle_reg;
                decel_cap <= decel_reg;
                jerk_cap <= jerk_reg;
                op_complete <= 1'b0;
                op_interrupted <= 1'b0;
                if (bad_input) begin
                    op_fault <= 1'b1;
                    fault_code <= (decel_reg == 32'h0000_0000 || decel_reg[31]) ?
                        GSS_FAULT_BAD_DECEL : GSS_FAULT_BAD_JERK;
                end else begin
                    op_busy <= 1'b1;
                    axes_controlled <= 1'b1;
                    group_state <= GSS_G_HALTING;
                    abort_pulse <= i_other_cmd_running;
                end
            end else if (run_fault) begin
                op_fault <= 1'b1;
                fault_code <= i_group_fault_halt ? GSS_FAULT_GROUP_HALT : GSS_FAULT_EXEC;
                op_busy <= 1'b0;
                axes_controlled <= 1'b0;
                group_state <= GSS_G_FAULT;
            end else if (done_now) begin
                op_complete <= 1'b1;
                op_busy <= 1'b0;
                // request already low, nothing holds the group halting
                if (!start_request) begin
                    group_state <= GSS_G_IDLE;
                end
            end else if (intr_now) begin
                op_interrupted <= 1'b1;
                op_busy <= 1'b0;
                axes_controlled <= 1'b0;
            end
            if (req_fall) begin
                op_fault <= 1'b0;
                fault_code <= GSS_FAULT_NONE;
                op_complete <= 1'b0;
                op_interrupted <= 1'b0;
                if (!op_busy || done_now) begin
                    axes_controlled <= 1'b0;
                end
                if (group_state == GSS_G_HALTING && (op_complete || done_now)) begin
                    group_state <= GSS_G_IDLE;
                end
            end
        end
    end

    // interrupt status, set wins over clear
    wire [3:0] irq_evt = {run_fault & scan_tick, intr_now & scan_tick, done_now & scan_tick, req_rise & ~op_busy};
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_stat <= 4'h0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_clr ? i_wb_dat[3:0] : 4'h0)) | irq_evt;
        end
    end
    assign o_irq = |(irq_stat & irq_en);

    // motion engine command
    // interrupt running group motion
    assign o_abort_other = abort_pulse;
    assign o_motion_cmd = '{halt: (group_state == GSS_G_HALTING) && axes_controlled,
        release_idle: group_state == GSS_G_IDLE,
        handle: handle_cap, decel_rate: decel_cap, jerk_limit: jerk_cap};
    assign o_group_state = group_state;
    assign o_handshake = '{op_complete: op_complete, op_busy: op_busy, axes_controlled: axes_controlled,
        op_interrupted: op_interrupted, op_fault: op_fault, fault_code: fault_code};

    busy_end_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(op_complete) |-> !op_busy)
        else $error("busy still high at completion");
    // complete one scan when request low
    complete_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        scan_tick && op_complete && !start_request && !req_rise |=> !op_complete)
        else $error("complete stuck");
    fault_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        req_fall |=> !op_fault && fault_code == GSS_FAULT_NONE)
        else $error("fault not cleared");
    halting_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        op_busy |-> group_state == GSS_G_HALTING)
        else $error("busy outside halting");
    fault_halt_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        scan_tick && run_fault && !req_rise && !req_fall |=> op_fault && !op_busy)
        else $error("fault not taken");
    start_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(op_busy) |-> $past(req_rise))
        else $error("busy without rising request");
    decel_cap_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(op_busy) |-> decel_cap == $past(decel_reg))
        else $error("decel not captured");
    idle_return_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        req_fall && op_complete && group_state == GSS_G_HALTING |=> group_state == GSS_G_IDLE)
        else $error("no return to idle");
    // idle when completion finds request low
    idle_late_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        scan_tick && done_now && !start_request |=> group_state == GSS_G_IDLE)
        else $error("late completion left group halting");
    handle_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        op_busy && $past(op_busy) |-> $stable(handle_cap))
        else $error("group handle changed while busy");
    complete_rest_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(op_complete) |-> $past(all_rest))
        else $error("complete before axes at rest");
    halting_done_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        op_complete && req_prev |-> group_state == GSS_G_HALTING)
        else $error("group left halting while request high");
    active_fall_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        req_fall && !op_busy |=> !axes_controlled)
        else $error("active kept after request fall");
    // active ends on fault or takeover
    active_end_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        scan_tick && (run_fault || intr_now) |=> !axes_controlled)
        else $error("active kept after fault or takeover");
    active_release_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        scan_tick && axes_controlled && !start_request && !op_busy |=> !axes_controlled)
        else $error("active not released");
    intr_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        scan_tick && op_interrupted && !start_request |=> !op_interrupted)
        else $error("interrupted flag stuck");
    intr_busy_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(op_interrupted) |-> !op_busy && !axes_controlled)
        else $error("busy kept after takeover");
    entry_fault_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        req_rise && !op_busy && bad_input |=> op_fault && !op_busy && fault_code != GSS_FAULT_NONE)
        else $error("bad input not faulted");
    abort_other_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        req_rise && !op_busy && !bad_input && i_other_cmd_running |=> o_abort_other && group_state == GSS_G_HALTING)
        else $error("running command not aborted");
endmodule : gss_group_axis_stop_sequencer

/* hw/gss_pkg.sv */
// package of constants, types and register map for the group stop sequencer
package gss_pkg;
    localparam int GSS_DATA_W = 32;
    localparam int GSS_AXES = 3;
    localparam int GSS_HANDLE_W = 8;
    localparam int GSS_ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] GSS_OFS_CTRL = 8'h00;
    localparam logic [7:0] GSS_OFS_DECEL = 8'h04;
    localparam logic [7:0] GSS_OFS_JERK = 8'h08;
    localparam logic [7:0] GSS_OFS_HANDLE = 8'h0C;
    localparam logic [7:0] GSS_OFS_STATUS = 8'h10;
    localparam logic [7:0] GSS_OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] GSS_OFS_IRQ_CLR = 8'h18;
    localparam logic [7:0] GSS_OFS_IRQ_EN = 8'h1C;
    localparam logic [7:0] GSS_OFS_SCAN = 8'h20;
    // field positions
    localparam int GSS_CTRL_START_BIT = 0;
    localparam int GSS_ST_DONE_BIT = 0;
    localparam int GSS_ST_BUSY_BIT = 1;
    localparam int GSS_ST_ACTIVE_BIT = 2;
    localparam int GSS_ST_INTR_BIT = 3;
    localparam int GSS_ST_FAULT_BIT = 4;
    localparam int GSS_ST_CODE_LSB = 8;
    localparam int GSS_ST_GSTATE_LSB = 16;
    // reset values
    localparam logic [31:0] GSS_DECEL_RST = 32'h0000_0000;
    localparam logic [31:0] GSS_JERK_RST = 32'h0000_0000;
    localparam logic [15:0] GSS_SCAN_RST = 16'h04E1;
    localparam logic [3:0] GSS_IRQ_EN_RST = 4'h0;
    // fault codes
    typedef enum logic [7:0] {
        GSS_FAULT_NONE = 8'h00,
        GSS_FAULT_BAD_DECEL = 8'h01,
        GSS_FAULT_BAD_JERK = 8'h02,
        GSS_FAULT_GROUP_HALT = 8'h03,
        GSS_FAULT_EXEC = 8'h04
    } gss_fault_code_t;
    // group motion states seen by the motion engine
    typedef enum logic [1:0] {
        GSS_G_IDLE = 2'b00,
        GSS_G_MOVING = 2'b01,
        GSS_G_HALTING = 2'b10,
        GSS_G_FAULT = 2'b11
    } gss_group_state_t;
    // command to the motion engine
    typedef struct packed {
        logic halt;
        logic release_idle;
        logic [GSS_HANDLE_W-1:0] handle;
        logic [31:0] decel_rate;
        logic [31:0] jerk_limit;
    } gss_motion_cmd_t;
    // handshake outputs
    typedef struct packed {
        logic op_complete;
        logic op_busy;
        logic axes_controlled;
        logic op_interrupted;
        logic op_fault;
        gss_fault_code_t fault_code;
    } gss_handshake_t;
endpackage : gss_pkg
